// file: fetch_front_defines.vh
// Constants shared by the flash fetch front end.
`ifndef FETCH_FRONT_DEFINES_VH
`define FETCH_FRONT_DEFINES_VH

// Queue and store geometry
`define QUEUE_DEPTH 4
`define QUEUE_PTR_W 2
`define QUEUE_CNT_W 3
`define QUEUE_FULL 3'h4
`define BT_ENTRIES 4
`define BT_IDX_W 2
`define BT_WORDS 4
`define BT_TAG_W 30
`define BT_TAGS_W 120
`define BT_AGE_OLDEST 2'h3

// Word addressing on the 32-bit burst interface
`define WORD_W 32
`define WORD_STEP 32'h00000004
`define BT_SPAN 32'h00000010
`define TAG_HI 31
`define TAG_LO 2

// Flash transaction kinds
`define KIND_W 2
`define KIND_PREFETCH 2'h0
`define KIND_LITERAL 2'h1
`define KIND_VECTOR 2'h2

`endif

// file: branch_target_lookup.v
// Parallel tag compare over all general entries of the branch target store.
`timescale 1ns/1ps
`default_nettype none
`include "fetch_front_defines.vh"

module branch_target_lookup (
   input wire [`BT_TAGS_W-1:0] tags,
   input wire [`BT_ENTRIES-1:0] valid,
   input wire [`BT_TAG_W-1:0] lookup_tag,
   output reg hit,
   output reg [`BT_IDX_W-1:0] hit_idx
);
   integer i;

   // =========================================================
   // Compare every entry at once
   // =========================================================
   always @* begin
      hit = 1'b0;
      hit_idx = {`BT_IDX_W{1'b0}};
      for (i = 0; i < `BT_ENTRIES; i = i + 1) begin
         if (valid[i] &&
             tags[i*`BT_TAG_W +: `BT_TAG_W] == lookup_tag) begin
            hit = 1'b1;
            hit_idx = i[`BT_IDX_W-1:0];
         end
      end
   end
endmodule // branch_target_lookup

`default_nettype wire

// file: flash_fetch_front.v
// Lookahead fetch queue with branch target store on the core fetch path.
`timescale 1ns/1ps
`default_nettype none
`include "fetch_front_defines.vh"

// Summary of operation
// - A four-word lookahead queue and a four-entry branch target store sit between the core and the flash.
// - The queue keeps fetching ahead into free slots whenever the flash port is idle, except in a redirect cycle or while a literal read is starting or pending.
// - Each queue fetch reads one 32-bit word and fetches may run back to back.
// - A non-sequential fetch flushes and reloads the queue after a store lookup, stalling the core on a miss.
// - Each general entry keeps a taken branch address and the first four words found there.
// - The lookup compares the address against all four entries at once and hits on a match with any valid entry.
// - On a hit the stored words go to the core while the queue restarts past them.
// - A fifth entry holds the vector read instruction so that fetching it does not stall.
// - Literal reads go to the flash without flushing the queue.
// - Words move over a dedicated 32-bit request and acknowledge flash interface.
module flash_fetch_front (
   input wire clk,
   input wire rst_n,
   input wire ce,
   input wire core_req,
   input wire [`WORD_W-1:0] core_addr,
   input wire core_data,
   input wire core_vec,
   output reg core_ack_reg,
   output reg [`WORD_W-1:0] core_rdata_reg,
   output reg flash_req_reg,
   output reg [`WORD_W-1:0] flash_addr_reg,
   input wire flash_ack,
   input wire [`WORD_W-1:0] flash_rdata
);
   // =========================================================
   // Storage
   // =========================================================
   reg [`WORD_W-1:0] queue_mem [0:`QUEUE_DEPTH-1];
   reg [`QUEUE_PTR_W-1:0] rd_ptr_reg;
   reg [`QUEUE_PTR_W-1:0] wr_ptr_reg;
   reg [`QUEUE_CNT_W-1:0] count_reg;
   reg [`WORD_W-1:0] head_addr_reg;
   reg [`WORD_W-1:0] fetch_addr_reg;
   reg epoch_reg;
   reg flash_epoch_reg;
   reg [`KIND_W-1:0] flash_kind_reg;

   reg [`WORD_W-1:0] bt_data [0:`BT_ENTRIES*`BT_WORDS-1];
   reg [`BT_TAG_W-1:0] bt_tag [0:`BT_ENTRIES-1];
   reg [1:0] bt_age [0:`BT_ENTRIES-1];
   reg [`BT_ENTRIES-1:0] bt_valid_reg;
   reg bt_active_reg;
   reg [`BT_IDX_W-1:0] bt_idx_reg;
   reg [1:0] bt_pos_reg;
   reg [`WORD_W-1:0] stream_addr_reg;
   reg fill_active_reg;
   reg [`BT_IDX_W-1:0] fill_idx_reg;
   reg [1:0] fill_cnt_reg;

   reg vec_valid_reg;
   reg [`BT_TAG_W-1:0] vec_tag_reg;
   reg [`WORD_W-1:0] vec_word_reg;

   reg lit_pend_reg;
   reg lit_wait_reg;
   reg [`WORD_W-1:0] lit_addr_reg;
   reg lit_vec_reg;

   // =========================================================
   // Request decode
   // =========================================================
   wire [`BT_TAGS_W-1:0] tags_flat;
   wire lk_hit;
   wire [`BT_IDX_W-1:0] lk_idx;
   wire [`BT_TAG_W-1:0] req_tag = core_addr[`TAG_HI:`TAG_LO];
   wire take = core_req && !core_ack_reg && !lit_wait_reg;
   wire is_inst = take && !core_data && !core_vec;
   wire seq_bt = is_inst && bt_active_reg && core_addr == stream_addr_reg;
   wire seq_q = is_inst && !bt_active_reg && core_addr == head_addr_reg;
   wire pop = seq_q && count_reg != {`QUEUE_CNT_W{1'b0}};
   wire redirect = is_inst && !seq_bt && !seq_q;
   wire bt_hit = redirect && lk_hit;
   wire vec_hit = take && core_vec && !core_data && vec_valid_reg &&
                  vec_tag_reg == req_tag;
   wire lit_start = take && (core_data || (core_vec && !vec_hit));
   wire fl_done = flash_req_reg && flash_ack;
   wire push = fl_done && flash_kind_reg == `KIND_PREFETCH &&
               flash_epoch_reg == epoch_reg;
   wire lit_done = fl_done && flash_kind_reg != `KIND_PREFETCH;
   wire port_free = !flash_req_reg || flash_ack;
   wire [`BT_IDX_W-1:0] victim;

   genvar g;
   generate
      for (g = 0; g < `BT_ENTRIES; g = g + 1) begin : g_tags
         assign tags_flat[g*`BT_TAG_W +: `BT_TAG_W] = bt_tag[g];
      end
   endgenerate

   branch_target_lookup u_lookup (
      .tags(tags_flat),
      .valid(bt_valid_reg),
      .lookup_tag(req_tag),
      .hit(lk_hit),
      .hit_idx(lk_idx)
   );

   // Invalid entries are taken first, else the oldest one
   function [`BT_IDX_W-1:0] pick_victim;
      input [`BT_ENTRIES-1:0] valid;
      input [7:0] ages;
      integer k;
      reg found;
      begin
         found = 1'b0;
         pick_victim = {`BT_IDX_W{1'b0}};
         for (k = `BT_ENTRIES-1; k >= 0; k = k - 1) begin
            if (ages[k*2 +: 2] == `BT_AGE_OLDEST && !found)
               pick_victim = k[`BT_IDX_W-1:0];
         end
         for (k = `BT_ENTRIES-1; k >= 0; k = k - 1) begin
            if (!valid[k]) begin
               pick_victim = k[`BT_IDX_W-1:0];
               found = 1'b1;
            end
         end
      end
   endfunction

   assign victim = pick_victim(bt_valid_reg,
      {bt_age[3], bt_age[2], bt_age[1], bt_age[0]});

   wire touch = bt_hit || (redirect && !lk_hit);
   wire [`BT_IDX_W-1:0] touch_idx = bt_hit ? lk_idx : victim;

   // =========================================================
   // Data arrays, no reset needed
   // =========================================================
   always @(posedge clk) begin
      if (ce) begin
         if (push) begin
            queue_mem[wr_ptr_reg] <= flash_rdata;
            if (fill_active_reg && !redirect)
               bt_data[{fill_idx_reg, fill_cnt_reg}] <= flash_rdata;
         end
         if (redirect && !lk_hit)
            bt_tag[victim] <= req_tag;
      end
   end

   // =========================================================
   // Control
   // =========================================================
   integer i;
   always @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         core_ack_reg <= 1'b0;
         core_rdata_reg <= {`WORD_W{1'b0}};
         flash_req_reg <= 1'b0;
         flash_addr_reg <= {`WORD_W{1'b0}};
         flash_kind_reg <= `KIND_PREFETCH;
         flash_epoch_reg <= 1'b0;
         rd_ptr_reg <= {`QUEUE_PTR_W{1'b0}};
         wr_ptr_reg <= {`QUEUE_PTR_W{1'b0}};
         count_reg <= {`QUEUE_CNT_W{1'b0}};
         head_addr_reg <= {`WORD_W{1'b0}};
         fetch_addr_reg <= {`WORD_W{1'b0}};
         epoch_reg <= 1'b0;
         bt_valid_reg <= {`BT_ENTRIES{1'b0}};
         bt_active_reg <= 1'b0;
         bt_idx_reg <= {`BT_IDX_W{1'b0}};
         bt_pos_reg <= 2'h0;
         stream_addr_reg <= {`WORD_W{1'b0}};
         fill_active_reg <= 1'b0;
         fill_idx_reg <= {`BT_IDX_W{1'b0}};
         fill_cnt_reg <= 2'h0;
         vec_valid_reg <= 1'b0;
         vec_tag_reg <= {`BT_TAG_W{1'b0}};
         vec_word_reg <= {`WORD_W{1'b0}};
         lit_pend_reg <= 1'b0;
         lit_wait_reg <= 1'b0;
         lit_addr_reg <= {`WORD_W{1'b0}};
         lit_vec_reg <= 1'b0;
         for (i = 0; i < `BT_ENTRIES; i = i + 1)
            bt_age[i] <= i[1:0];
      end else if (ce) begin
         core_ack_reg <= 1'b0;
         // Core side
         if (pop) begin
            core_ack_reg <= 1'b1;
            core_rdata_reg <= queue_mem[rd_ptr_reg];
            rd_ptr_reg <= rd_ptr_reg + 1'b1;
            head_addr_reg <= head_addr_reg + `WORD_STEP;
         end
         if (seq_bt) begin
            core_ack_reg <= 1'b1;
            core_rdata_reg <= bt_data[{bt_idx_reg, bt_pos_reg}];
            bt_pos_reg <= bt_pos_reg + 1'b1;
            stream_addr_reg <= stream_addr_reg + `WORD_STEP;
            if (bt_pos_reg == 2'h3)
               bt_active_reg <= 1'b0;
         end
         if (vec_hit) begin
            core_ack_reg <= 1'b1;
            core_rdata_reg <= vec_word_reg;
         end
         if (lit_start) begin
            lit_pend_reg <= 1'b1;
            lit_wait_reg <= 1'b1;
            lit_addr_reg <= core_addr;
            lit_vec_reg <= core_vec && !core_data;
         end
         if (lit_done) begin
            core_ack_reg <= 1'b1;
            core_rdata_reg <= flash_rdata;
            lit_wait_reg <= 1'b0;
            if (flash_kind_reg == `KIND_VECTOR) begin
               vec_valid_reg <= 1'b1;
               vec_tag_reg <= flash_addr_reg[`TAG_HI:`TAG_LO];
               vec_word_reg <= flash_rdata;
            end
         end
         // Queue fill and branch capture
         if (push) begin
            wr_ptr_reg <= wr_ptr_reg + 1'b1;
            fetch_addr_reg <= fetch_addr_reg + `WORD_STEP;
            if (fill_active_reg && !redirect) begin
               fill_cnt_reg <= fill_cnt_reg + 1'b1;
               if (fill_cnt_reg == 2'h3) begin
                  fill_active_reg <= 1'b0;
                  bt_valid_reg[fill_idx_reg] <= 1'b1;
               end
            end
         end
         if (push && !pop)
            count_reg <= count_reg + 1'b1;
         else if (pop && !push)
            count_reg <= count_reg - 1'b1;
         // Redirect: flush, then either stream the entry or reload
         if (redirect) begin
            epoch_reg <= !epoch_reg;
            count_reg <= {`QUEUE_CNT_W{1'b0}};
            rd_ptr_reg <= {`QUEUE_PTR_W{1'b0}};
            wr_ptr_reg <= {`QUEUE_PTR_W{1'b0}};
            if (lk_hit) begin
               core_ack_reg <= 1'b1;
               core_rdata_reg <= bt_data[{lk_idx, 2'h0}];
               bt_active_reg <= 1'b1;
               bt_idx_reg <= lk_idx;
               bt_pos_reg <= 2'h1;
               stream_addr_reg <= core_addr + `WORD_STEP;
               head_addr_reg <= core_addr + `BT_SPAN;
               fetch_addr_reg <= core_addr + `BT_SPAN;
               fill_active_reg <= 1'b0;
            end else begin
               bt_active_reg <= 1'b0;
               head_addr_reg <= core_addr;
               fetch_addr_reg <= core_addr;
               fill_active_reg <= 1'b1;
               fill_idx_reg <= victim;
               fill_cnt_reg <= 2'h0;
               bt_valid_reg[victim] <= 1'b0;
            end
         end
         if (touch) begin
            for (i = 0; i < `BT_ENTRIES; i = i + 1) begin
               if (i[`BT_IDX_W-1:0] == touch_idx)
                  bt_age[i] <= 2'h0;
               else if (bt_age[i] < bt_age[touch_idx])
                  bt_age[i] <= bt_age[i] + 1'b1;
            end
         end
         // Flash port; literals win, prefetch is held off in the redirect cycle and behind any stale request still in flight
         if (port_free) begin
            flash_req_reg <= 1'b0;
            if (lit_pend_reg) begin
               flash_req_reg <= 1'b1;
               flash_addr_reg <= lit_addr_reg;
               flash_kind_reg <= lit_vec_reg ? `KIND_VECTOR : `KIND_LITERAL;
               lit_pend_reg <= 1'b0;
            end else if (!lit_start && !redirect &&
                         count_reg + {2'h0, push} < `QUEUE_FULL) begin
               flash_req_reg <= 1'b1;
               flash_addr_reg <= push ? fetch_addr_reg + `WORD_STEP :
                                        fetch_addr_reg;
               flash_kind_reg <= `KIND_PREFETCH;
               flash_epoch_reg <= epoch_reg;
            end
         end
      end
   end
endmodule // flash_fetch_front

`default_nettype wire

// file: ffront_asserts.sv
// Port-level assertions for the flash fetch front end.
`timescale 1ns/1ps
`default_nettype none
`include "fetch_front_defines.vh"
module ffront_asserts (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic ce,
   input wire logic core_req,
   input wire logic [`WORD_W-1:0] core_addr,
   input wire logic core_data,
   input wire logic core_vec,
   input wire logic core_ack_reg,
   input wire logic [`WORD_W-1:0] core_rdata_reg,
   input wire logic flash_req_reg,
   input wire logic [`WORD_W-1:0] flash_addr_reg,
   input wire logic flash_ack,
   input wire logic [`WORD_W-1:0] flash_rdata
);
   default clocking @(posedge clk); endclocking
   default disable iff (!rst_n);
   // ==========================================================
   // Core side
   a_ack_one_pulse: assert property (core_ack_reg |=> !core_ack_reg)
      else $error("core ack held longer than one cycle");
   a_ack_after_req: assert property (core_ack_reg |->
      $past(core_req))
      else $error("core ack without a request");
   a_ack_bounded: assert property ($rose(core_req) |->
      ##[1:60] core_ack_reg)
      else $error("core request never answered");
   a_rdata_holds: assert property (!core_ack_reg |->
      $stable(core_rdata_reg))
      else $error("core read data changed without ack");
   // ==========================================================
   // Flash side
   a_flash_addr_held: assert property (
      flash_req_reg && !flash_ack |=>
      flash_req_reg && $stable(flash_addr_reg))
      else $error("flash request dropped or moved before ack");
   a_flash_word_align: assert property (flash_req_reg |->
      flash_addr_reg[1:0] == 2'h0)
      else $error("flash address not word aligned");
   a_prefetch_start: assert property ($rose(rst_n) |->
      ##[0:2] flash_req_reg)
      else $error("no prefetch after reset");
   a_literal_to_flash: assert property (
      $rose(core_req) && core_data |->
      ##[1:40] (flash_req_reg && flash_addr_reg == core_addr))
      else $error("literal read not sent to flash");
   a_literal_word: assert property (
      core_req && core_data && core_ack_reg |->
      $past(flash_ack) && core_rdata_reg == $past(flash_rdata))
      else $error("literal data not taken from flash word");
   c_literal: cover property (core_req && core_data && core_ack_reg);
   c_fast_ack: cover property ($rose(core_req) ##1 core_ack_reg);
   c_flash_burst: cover property (flash_ack ##1 flash_req_reg ##[1:3] flash_ack);
endmodule // ffront_asserts
bind flash_fetch_front ffront_asserts i_ffront_asserts (.clk(clk),
   .rst_n(rst_n), .ce(ce), .core_req(core_req), .core_addr(core_addr),
   .core_data(core_data), .core_vec(core_vec), .core_ack_reg(core_ack_reg),
   .core_rdata_reg(core_rdata_reg), .flash_req_reg(flash_req_reg),
   .flash_addr_reg(flash_addr_reg), .flash_ack(flash_ack),
   .flash_rdata(flash_rdata));
`default_nettype wire

// file: flash_model.sv
// Behavioural burst flash answering one word per request.
`timescale 1ns/1ps
`default_nettype none
module flash_model (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic [3:0] lat,
   input wire logic flash_req_reg,
   input wire logic [31:0] flash_addr_reg,
   output logic flash_ack,
   output logic [31:0] flash_rdata
);
   logic [3:0] cnt;
   initial begin
      flash_ack = 1'b0;
      flash_rdata = 32'h0;
      cnt = 4'h0;
   end
   // Data outside the ack cycle is inverted so stale words never look valid
   always @(posedge clk) begin
      #1;
      if (!rst_n || flash_ack) begin
         flash_ack <= 1'b0;
         flash_rdata <= ~flash_rdata;
         cnt <= 4'h0;
      end else if (flash_req_reg) begin
         if (cnt >= lat) begin
            flash_ack <= 1'b1;
            flash_rdata <= flash_addr_reg ^ 32'h5a3c96e1;
         end else
            cnt <= cnt + 4'h1;
      end
   end
endmodule // flash_model
`default_nettype wire

// file: testbench.sv
// Self-checking bench for the flash fetch front end.
`timescale 1ns/1ps
`default_nettype none
`define CHK(w, e, g) begin n_checks++; if ((g) !== (e)) begin \
   mismatches++; $display("CHECK FAILED %s expected %h seen %h", w, e, g); \
   end end
module testbench;
   logic clk, rst_n, ce, core_req, core_data, core_vec;
   logic [31:0] core_addr;
   logic [3:0] flash_lat;
   wire core_ack_reg, flash_req_reg, flash_ack;
   wire [31:0] core_rdata_reg, flash_addr_reg, flash_rdata;
   int mismatches = 0;
   int n_checks = 0;
   int cyc = 0;
   flash_fetch_front i_flash_fetch_front (.clk(clk), .rst_n(rst_n), .ce(ce),
      .core_req(core_req), .core_addr(core_addr), .core_data(core_data),
      .core_vec(core_vec), .core_ack_reg(core_ack_reg),
      .core_rdata_reg(core_rdata_reg), .flash_req_reg(flash_req_reg),
      .flash_addr_reg(flash_addr_reg), .flash_ack(flash_ack),
      .flash_rdata(flash_rdata));
   flash_model i_flash_model (.clk(clk), .rst_n(rst_n), .lat(flash_lat),
      .flash_req_reg(flash_req_reg), .flash_addr_reg(flash_addr_reg),
      .flash_ack(flash_ack), .flash_rdata(flash_rdata));
   // ==========================================================
   // Shared core-port tasks
   task automatic close_out;
      $display("checks %0d mismatches %0d", n_checks, mismatches);
      if (mismatches == 0 && n_checks > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
   endtask
   // Request is held through the edge that samples the ack
   task automatic fetch(input logic [31:0] a, input logic d, input logic v,
      output int n);
      @(posedge clk); #1;
      core_req = 1'b1; core_addr = a; core_data = d; core_vec = v; n = 0;
      do begin @(posedge clk); #1; n++; end
      while (core_ack_reg !== 1'b1 && n < 100);
      `CHK("ack", 1'b1, core_ack_reg)
      `CHK("rdata", a ^ 32'h5a3c96e1, core_rdata_reg)
      @(posedge clk); #1;
      core_req = 1'b0; core_data = 1'b0; core_vec = 1'b0;
   endtask
   task automatic hit(input logic [31:0] a, input logic v);
      int n;
      fetch(a, 1'b0, v, n);
      `CHK("hit cycles", 1, n)
   endtask
   task automatic fill(input logic [31:0] a);
      int n;
      fetch(a, 1'b0, 1'b0, n);
      `CHK("miss stall", 1'b1, n > 2)
      for (int i = 1; i < 4; i++) fetch(a + 4 * i, 1'b0, 1'b0, n);
      repeat (20) @(posedge clk);
      #1;
   endtask
   // ==========================================================
   // Scenarios
   task automatic t_seq;
      int n;
      flash_lat = 4'h1;
      for (int i = 0; i < 8; i++) fetch(4 * i, 1'b0, 1'b0, n);
      repeat (10) @(posedge clk);
      hit(32'h20, 1'b0);
   endtask
   // Flash port is idle first, so no answer is lost while frozen
   task automatic t_freeze;
      repeat (6) @(posedge clk);
      #1;
      ce = 1'b0; core_req = 1'b1; core_addr = 32'h24;
      repeat (4) begin
         @(posedge clk); #1;
         `CHK("frozen ack", 1'b0, core_ack_reg)
      end
      ce = 1'b1; core_req = 1'b0;
      hit(32'h24, 1'b0);
   endtask
   task automatic t_branch;
      flash_lat = 4'h3;
      fill(32'h100);
      fill(32'h200);
      hit(32'h100, 1'b0);
      for (int i = 1; i < 4; i++) hit(32'h100 + 4 * i, 1'b0);
      repeat (20) @(posedge clk);
      hit(32'h110, 1'b0);
   endtask
   // Entry 0x200 is least recently used when 0x500 needs a slot
   task automatic t_lru;
      flash_lat = 4'h0;
      fill(32'h300);
      fill(32'h400);
      fill(32'h500);
      hit(32'h100, 1'b0);
      hit(32'h300, 1'b0);
      hit(32'h400, 1'b0);
      fill(32'h200);
   endtask
   task automatic t_literal;
      int n;
      flash_lat = 4'h1;
      fill(32'h600);
      fetch(32'h900, 1'b1, 1'b0, n);
      hit(32'h610, 1'b0);
   endtask
   task automatic t_vector;
      int n;
      flash_lat = 4'h2;
      fetch(32'h18, 1'b0, 1'b1, n);
      `CHK("vector miss", 1'b1, n > 2)
      fill(32'h700);
      hit(32'h18, 1'b1);
   endtask
   // ==========================================================
   // Clock, timeout and main sequence
   initial begin
      clk = 1'b0;
      forever #10 clk = ~clk;
   end
   always @(posedge clk) begin
      cyc++;
      if (cyc == 5000) begin
         mismatches++;
         close_out;
      end
   end
   initial begin
      rst_n = 1'b0; ce = 1'b1; core_req = 1'b0; core_addr = 32'h0;
      core_data = 1'b0; core_vec = 1'b0; flash_lat = 4'h1;
      repeat (6) @(posedge clk);
      #1 rst_n = 1'b1;
      t_seq;
      t_freeze;
      t_branch;
      t_lru;
      t_literal;
      t_vector;
      close_out;
   end
endmodule // testbench
`default_nettype wire
